// File: design/fb_port_pkg.sv
// constants and types shared by the framebuffer memory port
package fb_port_pkg;
  localparam int DQ_W        = 128;
  localparam int ADDR_W      = 11;
  localparam int BANKS       = 2;
  localparam int LANES       = 16;
  localparam int ROM_ADDR_W  = 16;
  localparam int ROM_BYTE_W  = 8;
  localparam int ROM_ADDR_LO = 0;
  localparam int ROM_OE_BIT  = 16;
  localparam int ROM_WE_BIT  = 17;
  localparam int ROM_BYTE_LO = 24;
  localparam int ADDR_RSVD   = 10;
  localparam int STRAP_W     = 10;
  localparam int ROM_WAIT    = 4;
  localparam logic [3:0] ROM_WAIT_CNT = 4'h4;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MEM  = 4'b0010,
    ST_ROM  = 4'b0100,
    ST_DONE = 4'b1000
  } port_state_t;

  typedef logic [ADDR_W-1:0]  mem_addr_t;
  typedef logic [DQ_W-1:0]    mem_dq_t;
  typedef logic [LANES-1:0]   mem_mask_t;
endpackage

// File: design/fb_clk_if.sv
// clock fan-out carrier between port core and clock driver
`timescale 1ns/1ps
interface fb_clk_if;
  logic clk_run;
  logic loop_ok;
  modport core (output clk_run, input loop_ok);
  modport drv  (input clk_run, output loop_ok);
endinterface

// File: design/fb_clk_drv.sv
// memory clock fan-out and loop-back monitor
`timescale 1ns/1ps
module fb_clk_drv (
  // system
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // carrier
  fb_clk_if.drv     cif,
  // pins
  output logic      mem_clk_bank0_o,
  output logic      mem_clk_bank1_o,
  output logic      mem_clk_loop_out_o,
  input  wire logic mem_clk_loop_in_i
);
  logic clk_div;
  logic [2:0] loop_sync;

  // divide by two so the pin clocks come from flip-flops
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cif.clk_run) begin
      clk_div <= 1'b0;
    end else begin
      clk_div <= ~clk_div;
    end
  end

  // one copy per bank, a third only for the loop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_clk_bank0_o    <= 1'b0;
      mem_clk_bank1_o    <= 1'b0;
      mem_clk_loop_out_o <= 1'b0;
    end else begin
      mem_clk_bank0_o    <= clk_div;
      mem_clk_bank1_o    <= clk_div;
      mem_clk_loop_out_o <= clk_div;
    end
  end

  // loop input arrives from a pin: three stages
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      loop_sync <= 3'h0;
    end else begin
      loop_sync <= {loop_sync[1:0], mem_clk_loop_in_i};
    end
  end

  // loop seen alive once the two settled stages differ (toggling)
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cif.loop_ok <= 1'b0;
    end else if (loop_sync[2] != loop_sync[1]) begin
      cif.loop_ok <= 1'b1;
    end
  end
endmodule

// File: design/sgram_framebuffer_port.sv
// pin-level framebuffer memory port with shared boot ROM lines
`timescale 1ns/1ps
module sgram_framebuffer_port
(
  // system
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  // memory command request
  input  wire logic                         mem_req_i,
  input  wire logic [fb_port_pkg::BANKS-1:0] mem_bank_i,
  input  wire logic                         mem_row_i,
  input  wire logic                         mem_col_i,
  input  wire logic                         mem_wr_i,
  input  wire fb_port_pkg::mem_addr_t       mem_addr_i,
  input  wire fb_port_pkg::mem_mask_t       mem_mask_i,
  input  wire fb_port_pkg::mem_dq_t         mem_wdata_i,
  output logic                              mem_ack_o,
  output fb_port_pkg::mem_dq_t              mem_rdata_o,
  // boot rom request
  input  wire logic                         rom_req_i,
  input  wire logic                         rom_wr_i,
  input  wire logic [fb_port_pkg::ROM_ADDR_W-1:0] rom_addr_i,
  input  wire logic [fb_port_pkg::ROM_BYTE_W-1:0] rom_wdata_i,
  output logic                              rom_ack_o,
  output logic [fb_port_pkg::ROM_BYTE_W-1:0] rom_rdata_o,
  // status
  output logic [fb_port_pkg::STRAP_W-1:0]   strap_o,
  output logic                              clk_loop_ok_o,
  output logic                              busy_o,
  // memory pins
  input  wire fb_port_pkg::mem_dq_t         mem_dq_i,
  output fb_port_pkg::mem_dq_t              mem_dq_o,
  output fb_port_pkg::mem_dq_t              mem_dq_oe_o,
  input  wire fb_port_pkg::mem_addr_t       mem_addr_pin_i,
  output fb_port_pkg::mem_addr_t            mem_addr_o,
  output fb_port_pkg::mem_addr_t            mem_addr_oe_o,
  output logic                              mem_row_strobe_n_o,
  output logic                              mem_col_strobe_n_o,
  output logic                              mem_write_n_o,
  output logic [fb_port_pkg::BANKS-1:0]     mem_bank_sel_n_o,
  output fb_port_pkg::mem_mask_t            mem_byte_mask_o,
  output logic                              mem_clk_bank0_o,
  output logic                              mem_clk_bank1_o,
  output logic                              mem_clk_loop_out_o,
  input  wire logic                         mem_clk_loop_in_i,
  output logic                              mem_clk_en_o,
  output logic                              boot_rom_sel_n_o
);
  import fb_port_pkg::*;

  typedef enum logic [2:0] {
    OWN_NONE = 3'b001,
    OWN_MEM  = 3'b010,
    OWN_ROM  = 3'b100
  } line_owner_t;

  port_state_t                 state;
  port_state_t                 next_state;
  logic [3:0]                  wait_cnt;
  logic                        rom_cyc_wr;
  logic [STRAP_W-1:0]          strap_s1;
  logic [STRAP_W-1:0]          strap_s2;
  logic [STRAP_W-1:0]          strap_s3;
  logic                        in_reset_d;
  fb_clk_if                    cif ();
  line_owner_t                 line_owner;
  logic                        rom_owns;

  // lane-aligned view of a ROM byte on the shared lines
  function automatic mem_dq_t rom_lines(input logic [ROM_ADDR_W-1:0] a,
                                        input logic [ROM_BYTE_W-1:0] d,
                                        input logic wr);
    mem_dq_t v;
    v = '0;
    v[ROM_ADDR_LO +: ROM_ADDR_W] = a;
    v[ROM_BYTE_LO +: ROM_BYTE_W] = d;
    v[ROM_OE_BIT]                = wr;
    v[ROM_WE_BIT]                = ~wr;
    return v;
  endfunction

  // enable mask for the ROM lines; byte lanes only driven on writes
  function automatic mem_dq_t rom_oe(input logic wr);
    mem_dq_t v;
    v = '0;
    v[ROM_ADDR_LO +: ROM_ADDR_W] = {ROM_ADDR_W{1'b1}};
    v[ROM_OE_BIT]                = 1'b1;
    v[ROM_WE_BIT]                = 1'b1;
    v[ROM_BYTE_LO +: ROM_BYTE_W] = {ROM_BYTE_W{wr}};
    return v;
  endfunction

  fb_clk_drv u_clk (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .cif                (cif),
    .mem_clk_bank0_o    (mem_clk_bank0_o),
    .mem_clk_bank1_o    (mem_clk_bank1_o),
    .mem_clk_loop_out_o (mem_clk_loop_out_o),
    .mem_clk_loop_in_i  (mem_clk_loop_in_i)
  );

  assign cif.clk_run   = ~rst_i;
  assign clk_loop_ok_o = cif.loop_ok;
  assign mem_clk_en_o  = 1'b1;
  assign busy_o        = (state != ST_IDLE);

  // straps pass three stages while reset holds; last agreed value kept
  always_ff @(posedge clk_sys_i) begin
    strap_s1 <= mem_addr_pin_i[STRAP_W-1:0];
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  always_ff @(posedge clk_sys_i) begin
    in_reset_d <= rst_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i && in_reset_d && strap_s2 == strap_s3) begin
      strap_o <= strap_s3;
    end
  end

  // memory requests win over ROM when both arrive together
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (mem_req_i) begin
          next_state = ST_MEM;
        end else if (rom_req_i) begin
          next_state = ST_ROM;
        end
      end
      ST_MEM: begin
        next_state = ST_DONE;
      end
      ST_ROM: begin
        if (wait_cnt == CNT_ONE) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // rom access held for a fixed number of cycles to cover slow parts
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wait_cnt   <= CNT_ZERO;
      rom_cyc_wr <= 1'b0;
    end else if (state == ST_IDLE && !mem_req_i && rom_req_i) begin
      wait_cnt   <= ROM_WAIT_CNT;
      rom_cyc_wr <= rom_wr_i;
    end else if (state == ST_ROM && wait_cnt != CNT_ZERO) begin
      wait_cnt   <= wait_cnt - CNT_ONE;
    end
  end

  // owner of the shared lines, kept apart from the sequencer so that a bank
  // select can never open while a rom cycle still holds the low lanes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      line_owner <= OWN_NONE;
    end else begin
      case (next_state)
        ST_MEM: begin
          line_owner <= OWN_MEM;
        end
        ST_ROM: begin
          line_owner <= OWN_ROM;
        end
        ST_DONE: begin
          line_owner <= line_owner;
        end
        default: begin
          line_owner <= OWN_NONE;
        end
      endcase
    end
  end

  assign rom_owns = (line_owner == OWN_ROM);

  // command pins, driven for one cycle and then back at their idle levels
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_row_strobe_n_o <= 1'b1;
      mem_col_strobe_n_o <= 1'b1;
      mem_write_n_o      <= 1'b1;
      mem_bank_sel_n_o   <= '1;
      mem_byte_mask_o    <= '1;
    end else if (state == ST_IDLE && mem_req_i) begin
      mem_row_strobe_n_o <= ~mem_row_i;
      mem_col_strobe_n_o <= ~mem_col_i;
      mem_write_n_o      <= ~mem_wr_i;
      mem_bank_sel_n_o   <= ~mem_bank_i | {BANKS{rom_owns}};
      mem_byte_mask_o    <= mem_mask_i;
    end else if (state == ST_IDLE && rom_req_i) begin
      mem_row_strobe_n_o <= 1'b1;
      mem_col_strobe_n_o <= 1'b1;
      mem_write_n_o      <= 1'b1;
      mem_bank_sel_n_o   <= '1;
      mem_byte_mask_o    <= '1;
    end else if (state == ST_MEM || state == ST_DONE) begin
      mem_row_strobe_n_o <= 1'b1;
      mem_col_strobe_n_o <= 1'b1;
      mem_write_n_o      <= 1'b1;
      mem_bank_sel_n_o   <= '1;
      mem_byte_mask_o    <= '1;
    end
  end

  // address pins stay driven once used, so straps are readable only in reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_addr_o    <= '0;
      mem_addr_oe_o <= '0;
    end else if (state == ST_IDLE && mem_req_i) begin
      mem_addr_o    <= {1'b0, mem_addr_i[ADDR_RSVD-1:0]};
      mem_addr_oe_o <= '1;
    end
  end

  // shared data lines: memory write data or the rom view of the low lanes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_dq_o    <= '0;
      mem_dq_oe_o <= '0;
    end else if (state == ST_IDLE && mem_req_i) begin
      mem_dq_o    <= mem_wdata_i;
      mem_dq_oe_o <= {DQ_W{mem_wr_i}};
    end else if (state == ST_IDLE && rom_req_i) begin
      mem_dq_o    <= rom_lines(rom_addr_i, rom_wdata_i, rom_wr_i);
      mem_dq_oe_o <= rom_oe(rom_wr_i);
    end else if (state == ST_MEM || state == ST_DONE) begin
      mem_dq_oe_o <= '0;
    end
  end

  // rom select held low for the whole rom cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      boot_rom_sel_n_o <= 1'b1;
    end else if (state == ST_IDLE && mem_req_i) begin
      boot_rom_sel_n_o <= 1'b1;
    end else if (state == ST_IDLE && rom_req_i) begin
      boot_rom_sel_n_o <= 1'b0;
    end else if (state == ST_MEM || state == ST_DONE) begin
      boot_rom_sel_n_o <= 1'b1;
    end
  end

  // read data captured on the last rom cycle or one cycle after a memory command
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_rdata_o <= '0;
      rom_rdata_o <= '0;
    end else if (state == ST_MEM) begin
      mem_rdata_o <= mem_dq_i;
    end else if (state == ST_ROM && wait_cnt == CNT_ONE && !rom_cyc_wr) begin
      // a rom write leaves the last read byte in place
      rom_rdata_o <= mem_dq_i[ROM_BYTE_LO +: ROM_BYTE_W];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      rom_ack_o <= 1'b0;
    end else begin
      mem_ack_o <= (state == ST_MEM);
      rom_ack_o <= (state == ST_ROM && wait_cnt == CNT_ONE);
    end
  end
endmodule

// File: tb/fb_mem_model.sv
// far-side model: fixed memory read pattern, boot rom, strap resistors, clock loop
`timescale 1ns/1ps
module fb_mem_model
  import fb_port_pkg::*;
#(
  parameter mem_addr_t STRAP  = 11'h2a5,
  parameter mem_dq_t   RD_PAT = {4{32'hc3a5_0f96}}
) (
  input  wire logic       clk_sys_i,
  input  wire mem_dq_t    mem_dq_o,
  input  wire mem_dq_t    mem_dq_oe_o,
  input  wire mem_addr_t  mem_addr_o,
  input  wire mem_addr_t  mem_addr_oe_o,
  input  wire logic       mem_col_strobe_n_o,
  input  wire logic       mem_write_n_o,
  input  wire logic [1:0] mem_bank_sel_n_o,
  input  wire logic       boot_rom_sel_n_o,
  input  wire logic       mem_clk_loop_out_o,
  output mem_dq_t         mem_dq_i,
  output mem_addr_t       mem_addr_pin_i,
  output logic            mem_clk_loop_in_i
);
  mem_dq_t idle = {8{16'h5a3c}};
  mem_dq_t far;
  // released lines wander so stale data never reads back as good
  always_ff @(posedge clk_sys_i) begin
    idle <= ~idle;
  end
  always_comb begin
    far = idle;
    if (!(&mem_bank_sel_n_o) && !mem_col_strobe_n_o && mem_write_n_o) far = RD_PAT;
    if (!boot_rom_sel_n_o && !mem_dq_o[ROM_OE_BIT]) far[31:24] = ~mem_dq_o[7:0];
  end
  assign mem_dq_i = (mem_dq_o & mem_dq_oe_o) | (far & ~mem_dq_oe_o);
  // top line pulled down, the rest strapped
  assign mem_addr_pin_i = (mem_addr_o & mem_addr_oe_o) | (STRAP & ~mem_addr_oe_o);
  assign mem_clk_loop_in_i = mem_clk_loop_out_o;
endmodule

// File: tb/sgram_framebuffer_port_properties.sv
// concurrent checks on the framebuffer port pins
`timescale 1ns/1ps
module fb_port_properties
  import fb_port_pkg::*;
(
  input wire logic             clk_sys_i,
  input wire logic             rst_i,
  input wire logic             mem_req_i,
  input wire logic [BANKS-1:0] mem_bank_i,
  input wire logic             mem_row_i,
  input wire mem_mask_t        mem_mask_i,
  input wire logic             mem_ack_o,
  input wire logic             rom_req_i,
  input wire logic             rom_wr_i,
  input wire logic [15:0]      rom_addr_i,
  input wire logic             rom_ack_o,
  input wire logic             busy_o,
  input wire mem_dq_t          mem_dq_o,
  input wire mem_dq_t          mem_dq_oe_o,
  input wire mem_addr_t        mem_addr_o,
  input wire logic             mem_row_strobe_n_o,
  input wire logic [BANKS-1:0] mem_bank_sel_n_o,
  input wire mem_mask_t        mem_byte_mask_o,
  input wire logic             mem_clk_bank0_o,
  input wire logic             mem_clk_bank1_o,
  input wire logic             mem_clk_loop_out_o,
  input wire logic             mem_clk_en_o,
  input wire logic             boot_rom_sel_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire mem_take = mem_req_i && !busy_o;
  wire rom_take = rom_req_i && !mem_req_i && !busy_o;
  mem_ack_lat_a: assert property (mem_take |-> ##2 mem_ack_o)
    else $error("memory ack late");
  mem_pins_a: assert property (mem_take |-> ##1 (mem_bank_sel_n_o == ~$past(mem_bank_i)
    && mem_row_strobe_n_o == !$past(mem_row_i) && mem_byte_mask_o == $past(mem_mask_i)))
    else $error("memory command pins wrong");
  rom_ack_lat_a: assert property (rom_take |-> ##5 rom_ack_o)
    else $error("rom ack late");
  rom_lines_a: assert property ($fell(boot_rom_sel_n_o) |-> mem_dq_o[15:0] == $past(rom_addr_i)
    && mem_dq_o[16] == $past(rom_wr_i) && mem_dq_o[17] == !$past(rom_wr_i) && &mem_dq_oe_o[17:0])
    else $error("rom lines wrong");
  rom_hold_a: assert property ($fell(boot_rom_sel_n_o) |-> !boot_rom_sel_n_o[*4])
    else $error("rom select too short");
  rom_excl_a: assert property (!boot_rom_sel_n_o |-> &mem_bank_sel_n_o)
    else $error("bank selected during rom cycle");
  addr_rsvd_a: assert property (!mem_addr_o[ADDR_RSVD])
    else $error("reserved address line driven");
  clk_fan_a: assert property (mem_clk_bank0_o == mem_clk_bank1_o
    && mem_clk_bank0_o == mem_clk_loop_out_o) else $error("memory clocks differ");
  clk_run_a: assert property (!$past(rst_i, 2) |-> mem_clk_bank0_o != $past(mem_clk_bank0_o))
    else $error("memory clock stalled");
  clk_en_a: assert property (mem_clk_en_o)
    else $error("clock enable low");
endmodule
bind sgram_framebuffer_port fb_port_properties u_props (
  .clk_sys_i          (clk_sys_i),
  .rst_i              (rst_i),
  .mem_req_i          (mem_req_i),
  .mem_bank_i         (mem_bank_i),
  .mem_row_i          (mem_row_i),
  .mem_mask_i         (mem_mask_i),
  .mem_ack_o          (mem_ack_o),
  .rom_req_i          (rom_req_i),
  .rom_wr_i           (rom_wr_i),
  .rom_addr_i         (rom_addr_i),
  .rom_ack_o          (rom_ack_o),
  .busy_o             (busy_o),
  .mem_dq_o           (mem_dq_o),
  .mem_dq_oe_o        (mem_dq_oe_o),
  .mem_addr_o         (mem_addr_o),
  .mem_row_strobe_n_o (mem_row_strobe_n_o),
  .mem_bank_sel_n_o   (mem_bank_sel_n_o),
  .mem_byte_mask_o    (mem_byte_mask_o),
  .mem_clk_bank0_o    (mem_clk_bank0_o),
  .mem_clk_bank1_o    (mem_clk_bank1_o),
  .mem_clk_loop_out_o (mem_clk_loop_out_o),
  .mem_clk_en_o       (mem_clk_en_o),
  .boot_rom_sel_n_o   (boot_rom_sel_n_o)
);

// File: tb/tb.sv
// self-checking bench for the framebuffer port
`timescale 1ns/1ps
module tb;
  import fb_port_pkg::*;
  localparam mem_addr_t STRAP  = 11'h2a5;
  localparam mem_dq_t   RD_PAT = {4{32'hc3a5_0f96}};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic mem_req_i, mem_row_i, mem_col_i, mem_wr_i, rom_req_i, rom_wr_i, mem_ack_o, rom_ack_o;
  logic clk_loop_ok_o, busy_o, mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_n_o;
  logic mem_clk_bank0_o, mem_clk_bank1_o, mem_clk_loop_out_o, mem_clk_loop_in_i;
  logic mem_clk_en_o, boot_rom_sel_n_o;
  logic [1:0] mem_bank_i, mem_bank_sel_n_o;
  mem_addr_t  mem_addr_i, mem_addr_o, mem_addr_oe_o, mem_addr_pin_i;
  mem_mask_t  mem_mask_i, mem_byte_mask_o;
  mem_dq_t    mem_wdata_i, mem_rdata_o, mem_dq_i, mem_dq_o, mem_dq_oe_o;
  logic [15:0] rom_addr_i;
  logic [7:0] rom_wdata_i, rom_rdata_o;
  logic [9:0] strap_o;
  int err_count = 0, n_compared = 0, cycles = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  sgram_framebuffer_port u_dut (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .mem_req_i          (mem_req_i),
    .mem_bank_i         (mem_bank_i),
    .mem_row_i          (mem_row_i),
    .mem_col_i          (mem_col_i),
    .mem_wr_i           (mem_wr_i),
    .mem_addr_i         (mem_addr_i),
    .mem_mask_i         (mem_mask_i),
    .mem_wdata_i        (mem_wdata_i),
    .mem_ack_o          (mem_ack_o),
    .mem_rdata_o        (mem_rdata_o),
    .rom_req_i          (rom_req_i),
    .rom_wr_i           (rom_wr_i),
    .rom_addr_i         (rom_addr_i),
    .rom_wdata_i        (rom_wdata_i),
    .rom_ack_o          (rom_ack_o),
    .rom_rdata_o        (rom_rdata_o),
    .strap_o            (strap_o),
    .clk_loop_ok_o      (clk_loop_ok_o),
    .busy_o             (busy_o),
    .mem_dq_i           (mem_dq_i),
    .mem_dq_o           (mem_dq_o),
    .mem_dq_oe_o        (mem_dq_oe_o),
    .mem_addr_pin_i     (mem_addr_pin_i),
    .mem_addr_o         (mem_addr_o),
    .mem_addr_oe_o      (mem_addr_oe_o),
    .mem_row_strobe_n_o (mem_row_strobe_n_o),
    .mem_col_strobe_n_o (mem_col_strobe_n_o),
    .mem_write_n_o      (mem_write_n_o),
    .mem_bank_sel_n_o   (mem_bank_sel_n_o),
    .mem_byte_mask_o    (mem_byte_mask_o),
    .mem_clk_bank0_o    (mem_clk_bank0_o),
    .mem_clk_bank1_o    (mem_clk_bank1_o),
    .mem_clk_loop_out_o (mem_clk_loop_out_o),
    .mem_clk_loop_in_i  (mem_clk_loop_in_i),
    .mem_clk_en_o       (mem_clk_en_o),
    .boot_rom_sel_n_o   (boot_rom_sel_n_o)
  );
  fb_mem_model #(.STRAP(STRAP), .RD_PAT(RD_PAT)) u_far (
    .clk_sys_i          (clk_sys_i),
    .mem_dq_o           (mem_dq_o),
    .mem_dq_oe_o        (mem_dq_oe_o),
    .mem_addr_o         (mem_addr_o),
    .mem_addr_oe_o      (mem_addr_oe_o),
    .mem_col_strobe_n_o (mem_col_strobe_n_o),
    .mem_write_n_o      (mem_write_n_o),
    .mem_bank_sel_n_o   (mem_bank_sel_n_o),
    .boot_rom_sel_n_o   (boot_rom_sel_n_o),
    .mem_clk_loop_out_o (mem_clk_loop_out_o),
    .mem_dq_i           (mem_dq_i),
    .mem_addr_pin_i     (mem_addr_pin_i),
    .mem_clk_loop_in_i  (mem_clk_loop_in_i)
  );
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic mem_op(input logic [1:0] bank, input logic row, col, wr, input mem_addr_t addr,
                        input mem_mask_t mask);
    @(posedge clk_sys_i);
    {mem_req_i, mem_bank_i, mem_row_i, mem_col_i, mem_wr_i} <= {1'b1, bank, row, col, wr};
    {mem_addr_i, mem_mask_i} <= {addr, mask};
    @(posedge clk_sys_i);
    mem_req_i <= 1'b0;
    #1;
    chk("bank_sel", {~bank}, mem_bank_sel_n_o);
    chk("strobes", {~row, ~col, ~wr}, {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_n_o});
    chk("mask", mask, mem_byte_mask_o);
    chk("busy", 1'b1, busy_o);
    chk("addr", {1'b0, addr[9:0]}, mem_addr_o);
    if (wr) chk("wdata", {~RD_PAT}, mem_dq_o & mem_dq_oe_o);
    @(posedge clk_sys_i);
    #1;
    chk("mem_ack", 1'b1, mem_ack_o);
    if (col && !wr) chk("rdata", RD_PAT, mem_rdata_o);
    @(posedge clk_sys_i);
    #1;
    chk("busy_end", 1'b0, busy_o);
  endtask
  task automatic rom_op(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    {rom_req_i, rom_wr_i, rom_addr_i, rom_wdata_i} <= {1'b1, wr, addr, data};
    @(posedge clk_sys_i);
    rom_req_i <= 1'b0;
    #1;
    chk("rom_sel", 3'b110, {mem_bank_sel_n_o, boot_rom_sel_n_o});
    chk("rom_lines", {~wr, wr, addr}, mem_dq_o[17:0]);
    if (wr) chk("rom_wbyte", data, mem_dq_o[31:24]);
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("rom_ack", 1'b1, rom_ack_o);
    if (!wr) chk("rom_rbyte", {~addr[7:0]}, rom_rdata_o);
    @(posedge clk_sys_i);
  endtask
  task automatic t_prio;
    @(posedge clk_sys_i);
    {mem_req_i, mem_bank_i, mem_row_i, mem_col_i, mem_wr_i} <= 6'b110100;
    {rom_req_i, rom_wr_i, rom_addr_i} <= {2'b10, 16'h00ff};
    @(posedge clk_sys_i);
    mem_req_i <= 1'b0;
    #1;
    chk("mem_first", 3'b011, {mem_bank_sel_n_o, boot_rom_sel_n_o});
    for (int i = 0; i < 8 && boot_rom_sel_n_o; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk("rom_after", 3'b110, {mem_bank_sel_n_o, boot_rom_sel_n_o});
    @(posedge clk_sys_i);
    rom_req_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    {mem_req_i, mem_row_i, mem_col_i, mem_wr_i, rom_req_i, rom_wr_i} = '0;
    {mem_bank_i, mem_addr_i, mem_mask_i, rom_addr_i, rom_wdata_i} = '0;
    mem_wdata_i = ~RD_PAT;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk("addr_oe", 11'h000, mem_addr_oe_o);
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("strap", {STRAP[9:0]}, strap_o);
    chk("loop_ok", 1'b1, clk_loop_ok_o);
    chk("clk_en", 1'b1, mem_clk_en_o);
    mem_op(2'b01, 1'b1, 1'b0, 1'b0, 11'h7ff, 16'hffff);
    mem_op(2'b10, 1'b0, 1'b1, 1'b1, 11'h3ff, 16'h0001);
    mem_op(2'b11, 1'b0, 1'b1, 1'b0, 11'h000, 16'h8000);
    rom_op(1'b0, 16'hffff, 8'h00);
    rom_op(1'b1, 16'h0000, 8'ha5);
    rom_op(1'b0, 16'h1234, 8'h00);
    t_prio();
    final_report();
  end
endmodule
